// ---- rtl/sfrt_defs.svh ----
`ifndef SFRT_DEFS_SVH
`define SFRT_DEFS_SVH

// ****************************************************************
// register map, byte addresses on the bus
// ****************************************************************
`define SFRT_ADDR_W 8
`define SFRT_OFS_CTRL 8'h00
`define SFRT_OFS_DATA 8'h04
`define SFRT_OFS_VECTOR 8'h08
`define SFRT_OFS_STATUS 8'h0c

// ****************************************************************
// transmit_control field positions and reset value
// ****************************************************************
`define SFRT_BIT_NOCRC 0
`define SFRT_BIT_CRC 1
`define SFRT_BIT_SINGLE 2
`define SFRT_BIT_NORM_BIT_FORMAT_SELECT 3
`define SFRT_BIT_EOD 4
`define SFRT_CTRL_RST 8'h00

// ****************************************************************
// state vector codes and bus answers
// ****************************************************************
`define SFRT_VEC_NONE 8'h00
`define SFRT_VEC_TX_BUFFER_EMPTY_FLAG 8'h10
`define SFRT_VEC_ARB 8'h14
`define SFRT_RESP_OKAY 2'h0
`define SFRT_RESP_SLVERR 2'h2

`endif

// ---- rtl/sfrt_pkg.sv ----
`include "sfrt_defs.svh"

package sfrt_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_MSG, ST_NORM, ST_IFR, ST_RETRY, ST_TAIL_CRC, ST_TAIL_EOD,
    ST_TRAILER
  } sfrt_state_type;

  typedef enum logic [2:0] {
    SYM_BYTE, SYM_CRC, SYM_NORM, SYM_EOD, SYM_ONES
  } sfrt_sym_type;

  typedef enum logic [1:0] {
    MODE_NONE, MODE_SINGLE, MODE_CRC, MODE_NOCRC
  } sfrt_mode_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [`SFRT_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic eod_req;
    logic single_req;
    logic crc_req;
    logic nocrc_req;
    logic norm_bit_format_select;
    logic [7:0] buf_data;
    logic buf_full;
    logic [7:0] shift_data;
    logic shift_full;
    logic tx_buffer_empty_flag;
    logic vec_armed;
    logic arb_flag;
    logic eod_seen;
    sfrt_state_type state;
    sfrt_mode_type act;
    logic sym_valid;
    sfrt_sym_type sym_kind;
    logic [7:0] sym_data;
    logic sym_norm;
    logic in_flight;
  } sfrt_regs_type;

  function automatic sfrt_mode_type sfrt_decode_mode(
    input logic single,
    input logic crc,
    input logic nocrc
  );
    if (single) begin
      return MODE_SINGLE;
    end else if (crc) begin
      return MODE_CRC;
    end else if (nocrc) begin
      return MODE_NOCRC;
    end
    return MODE_NONE;
  endfunction : sfrt_decode_mode

endpackage : sfrt_pkg

// ---- rtl/sfrt_tx_control.sv ----
`include "sfrt_defs.svh"

module sfrt_tx_control (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`SFRT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SFRT_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sym_valid,
  output sfrt_pkg::sfrt_sym_type sym_kind,
  output logic [7:0] sym_data,
  output logic sym_norm,
  input wire logic sym_ready,
  input wire logic tx_done,
  input wire logic crc_first_bit,
  input wire logic arb_lost,
  input wire logic arb_lost_last_bit,
  input wire logic bus_error,
  input wire logic rx_eod_ok,
  input wire logic rx_eof,
  input wire logic rx_byte_done,
  input wire logic peer_norm_seen
);
  import sfrt_pkg::*;

  sfrt_regs_type r;
  sfrt_regs_type next_r;
  sfrt_mode_type eff;
  logic sw_wr;
  logic sw_ctrl_wr;
  logic sw_eod_wr;
  logic idle_tx;
  logic sending;
  logic [7:0] ctrl_rd;
  logic [7:0] vec_rd;

  // ****************************************************************
  // decode of the pending bus write
  // ****************************************************************
  assign sw_wr = !r.awready && !r.wready && !r.bvalid;
  assign sw_ctrl_wr = sw_wr && r.awaddr == `SFRT_OFS_CTRL && r.wstrb[0];
  assign sw_eod_wr = sw_ctrl_wr && r.wdata[`SFRT_BIT_EOD];
  assign eff = sfrt_decode_mode(r.single_req, r.crc_req, r.nocrc_req);
  assign idle_tx = !r.sym_valid && !r.in_flight;
  assign sending = r.state inside {ST_MSG, ST_IFR, ST_NORM, ST_TAIL_CRC,
    ST_TAIL_EOD};

  always_comb begin
    ctrl_rd = `SFRT_CTRL_RST;
    ctrl_rd[`SFRT_BIT_NOCRC] = r.nocrc_req;
    ctrl_rd[`SFRT_BIT_CRC] = r.crc_req;
    ctrl_rd[`SFRT_BIT_SINGLE] = r.single_req;
    ctrl_rd[`SFRT_BIT_NORM_BIT_FORMAT_SELECT] = r.norm_bit_format_select;
    ctrl_rd[`SFRT_BIT_EOD] = r.eod_req;
    if (r.arb_flag) begin
      vec_rd = `SFRT_VEC_ARB;
    end else if (r.tx_buffer_empty_flag) begin
      vec_rd = `SFRT_VEC_TX_BUFFER_EMPTY_FLAG;
    end else begin
      vec_rd = `SFRT_VEC_NONE;
    end
  end

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    logic tx_buffer_empty_flag_set;
    logic arb_set;
    logic clr_act;
    tx_buffer_empty_flag_set = 1'b0;
    arb_set = 1'b0;
    clr_act = 1'b0;
    next_r = r;

    // symbol channel to the encoder
    if (r.sym_valid && sym_ready) begin
      next_r.sym_valid = 1'b0;
      next_r.in_flight = 1'b1;
      // a single response keeps its byte for a retry
      if (r.sym_kind == SYM_BYTE && r.act != MODE_SINGLE) begin
        next_r.shift_full = 1'b0;
      end
    end
    if (tx_done) begin
      next_r.in_flight = 1'b0;
    end
    if (rx_eod_ok) begin
      next_r.eod_seen = 1'b1;
    end
    if (rx_eof) begin
      next_r.eod_seen = 1'b0;
    end

    // holding register feeds the shifter stage
    if ((r.state == ST_MSG || (r.state == ST_IFR && r.act != MODE_SINGLE))
        && !r.shift_full && r.buf_full) begin
      next_r.shift_data = r.buf_data;
      next_r.shift_full = 1'b1;
      next_r.buf_full = 1'b0;
      tx_buffer_empty_flag_set = 1'b1;
    end

    case (r.state)
      ST_IDLE: begin
        if (eff != MODE_NONE) begin
          if (rx_eod_ok && !r.eod_seen) begin
            next_r.act = eff;
            next_r.shift_data = r.buf_data;
            next_r.shift_full = r.buf_full;
            next_r.buf_full = 1'b0;
            tx_buffer_empty_flag_set = r.buf_full && eff != MODE_SINGLE;
            // another responder already drove the norm bit
            next_r.state = peer_norm_seen ? ST_IFR : ST_NORM;
          end
        end else if (r.buf_full && !r.eod_seen) begin
          next_r.act = MODE_NONE;
          next_r.state = ST_MSG;
        end
      end
      ST_NORM: begin
        if (idle_tx) begin
          next_r.sym_valid = 1'b1;
          next_r.sym_kind = SYM_NORM;
          next_r.sym_norm = (r.act == MODE_CRC) ^ r.norm_bit_format_select;
        end
        if (tx_done) begin
          next_r.state = ST_IFR;
        end
      end
      ST_MSG, ST_IFR: begin
        if (r.act == MODE_SINGLE && tx_done) begin
          next_r.shift_full = 1'b0;
          next_r.single_req = 1'b0;
          next_r.state = ST_IDLE;
        end else if (idle_tx && r.shift_full) begin
          next_r.sym_valid = 1'b1;
          next_r.sym_kind = SYM_BYTE;
          next_r.sym_data = r.shift_data;
        end else if (idle_tx && !r.buf_full) begin
          if (r.act == MODE_SINGLE) begin
            clr_act = 1'b1;
            next_r.state = ST_IDLE;
          end else if (r.eod_req) begin
            next_r.sym_valid = 1'b1;
            if (r.act == MODE_NOCRC) begin
              next_r.sym_kind = SYM_EOD;
              next_r.state = ST_TAIL_EOD;
            end else begin
              next_r.sym_kind = SYM_CRC;
              next_r.state = ST_TAIL_CRC;
            end
          end else begin
            // underrun: the trailing ones break the byte boundary
            clr_act = 1'b1;
            next_r.state = ST_TRAILER;
          end
        end
      end
      ST_RETRY: begin
        if (rx_byte_done) begin
          next_r.state = ST_IFR;
        end
      end
      ST_TAIL_CRC: begin
        if (r.act == MODE_NONE) begin
          if (crc_first_bit) begin
            next_r.eod_req = 1'b0;
          end
          if (tx_done) begin
            next_r.state = ST_IDLE;
          end
        end else if (tx_done) begin
          next_r.sym_valid = 1'b1;
          next_r.sym_kind = SYM_EOD;
          next_r.state = ST_TAIL_EOD;
        end
      end
      ST_TAIL_EOD: begin
        if (rx_eod_ok) begin
          next_r.eod_req = 1'b0;
          clr_act = 1'b1;
          next_r.in_flight = 1'b0;
          next_r.state = ST_IDLE;
        end
      end
      ST_TRAILER: begin
        if (idle_tx) begin
          next_r.sym_valid = 1'b1;
          next_r.sym_kind = SYM_ONES;
        end
        if (tx_done) begin
          next_r.state = ST_IDLE;
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    // ****************************************************************
    // arbitration loss and bus errors
    // ****************************************************************
    if (arb_lost && sending) begin
      arb_set = 1'b1;
      next_r.in_flight = 1'b0;
      next_r.sym_valid = 1'b0;
      if (r.act == MODE_SINGLE) begin
        next_r.state = ST_RETRY;
      end else begin
        next_r.shift_full = 1'b0;
        clr_act = 1'b1;
        next_r.state = arb_lost_last_bit ? ST_TRAILER : ST_IDLE;
      end
    end
    if (clr_act) begin
      case (r.act)
        MODE_SINGLE: next_r.single_req = 1'b0;
        MODE_CRC: next_r.crc_req = 1'b0;
        MODE_NOCRC: next_r.nocrc_req = 1'b0;
        default: ;
      endcase
    end
    if (bus_error) begin
      next_r.state = ST_IDLE;
      next_r.sym_valid = 1'b0;
      next_r.in_flight = 1'b0;
      next_r.shift_full = 1'b0;
      next_r.eod_req = 1'b0;
      next_r.single_req = 1'b0;
      next_r.crc_req = 1'b0;
      next_r.nocrc_req = 1'b0;
    end

    // ****************************************************************
    // bus write side
    // ****************************************************************
    if (r.awready && s_axi_awvalid) begin
      next_r.awready = 1'b0;
      next_r.awaddr = s_axi_awaddr;
    end
    if (r.wready && s_axi_wvalid) begin
      next_r.wready = 1'b0;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (sw_wr) begin
      next_r.bvalid = 1'b1;
      next_r.bresp = `SFRT_RESP_OKAY;
      case (r.awaddr)
        `SFRT_OFS_CTRL: begin
          if (r.wstrb[0]) begin
            next_r.norm_bit_format_select = r.wdata[`SFRT_BIT_NORM_BIT_FORMAT_SELECT];
            // bits read back as written; a fresh set is refused late
            next_r.single_req = r.wdata[`SFRT_BIT_SINGLE]
              && !(r.eod_seen && !r.single_req);
            next_r.crc_req = r.wdata[`SFRT_BIT_CRC]
              && !(r.eod_seen && !r.crc_req);
            next_r.nocrc_req = r.wdata[`SFRT_BIT_NOCRC]
              && !(r.eod_seen && !r.nocrc_req);
          end
        end
        `SFRT_OFS_DATA: begin
          if (r.wstrb[0]) begin
            next_r.buf_data = r.wdata[7:0];
            next_r.buf_full = 1'b1;
            if (r.vec_armed) begin
              next_r.tx_buffer_empty_flag = 1'b0;
              next_r.vec_armed = 1'b0;
            end
          end
        end
        `SFRT_OFS_VECTOR, `SFRT_OFS_STATUS: ;
        default: next_r.bresp = `SFRT_RESP_SLVERR;
      endcase
    end
    if (sw_eod_wr) begin
      next_r.eod_req = 1'b1;
      next_r.single_req = 1'b0;
      if (r.act == MODE_SINGLE && r.state inside {ST_IFR, ST_RETRY}) begin
        next_r.state = ST_IDLE;
        next_r.shift_full = 1'b0;
        next_r.sym_valid = 1'b0;
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    // ****************************************************************
    // bus read side
    // ****************************************************************
    if (r.arready && s_axi_arvalid) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = `SFRT_RESP_OKAY;
      next_r.rdata = 32'h0;
      case (s_axi_araddr)
        `SFRT_OFS_CTRL: next_r.rdata[7:0] = ctrl_rd;
        `SFRT_OFS_DATA: next_r.rdata[7:0] = r.buf_data;
        `SFRT_OFS_VECTOR: begin
          next_r.rdata[7:0] = vec_rd;
          next_r.arb_flag = 1'b0;
          next_r.vec_armed = r.tx_buffer_empty_flag;
        end
        `SFRT_OFS_STATUS: begin
          next_r.rdata = {22'h0, r.eod_seen, r.in_flight, r.buf_full,
            r.shift_full, r.act, r.state};
        end
        default: next_r.rresp = `SFRT_RESP_SLVERR;
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end

    // hardware sets win over software clears, except end-of-data
    if (tx_buffer_empty_flag_set && !sw_eod_wr) begin
      next_r.tx_buffer_empty_flag = 1'b1;
    end
    if (sw_eod_wr) begin
      next_r.tx_buffer_empty_flag = 1'b0;
    end
    if (arb_set) begin
      next_r.arb_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign sym_valid = r.sym_valid;
  assign sym_kind = r.sym_kind;
  assign sym_data = r.sym_data;
  assign sym_norm = r.sym_norm;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence crc_taken;
    r.sym_valid && sym_ready && r.sym_kind == SYM_CRC;
  endsequence
  sequence lost_single;
    arb_lost && r.act == MODE_SINGLE && r.state == ST_IFR && !bus_error
      && !sw_eod_wr;
  endsequence
  sequence lost_multi_last;
    arb_lost && arb_lost_last_bit && r.act inside {MODE_CRC, MODE_NOCRC}
      && r.state == ST_IFR && !bus_error;
  endsequence
  sequence ones_out;
    r.sym_valid && r.sym_kind == SYM_ONES;
  endsequence

  a_crc_needs_eod: assert property (crc_taken |-> r.eod_req)
    else $error("crc sent without end-of-data request");
  a_crc_after_bytes: assert property (
    $rose(r.sym_valid) && r.sym_kind == SYM_CRC |-> !r.shift_full)
    else $error("crc issued ahead of a staged byte");
  a_eod_drops_tx_buffer_empty_flag: assert property (sw_eod_wr |=> !r.tx_buffer_empty_flag)
    else $error("buffer empty flag survived end-of-data");
  a_crc_bit_clear: assert property (
    r.state == ST_TAIL_CRC && r.act == MODE_NONE && crc_first_bit
      && !sw_ctrl_wr |=> !r.eod_req)
    else $error("end-of-data request not cleared at crc bit");
  a_ifr_eod_clear: assert property (
    r.state == ST_TAIL_EOD && rx_eod_ok && !sw_ctrl_wr
      |=> !r.eod_req && r.state == ST_IDLE)
    else $error("response end not cleared on echoed end-of-data");
  a_mode_priority: assert property (
    r.state == ST_IDLE && r.single_req && rx_eod_ok && !r.eod_seen
      |=> r.act == MODE_SINGLE)
    else $error("single response lost its priority");
  a_norm_format: assert property (
    r.sym_valid && r.sym_kind == SYM_NORM
      |-> r.sym_norm == ((r.act == MODE_CRC) ^ r.norm_bit_format_select))
    else $error("normalization bit has wrong value");
  a_locked_resp: assert property (
    r.eod_seen && !r.crc_req && !r.single_req |=> !r.crc_req && !r.single_req)
    else $error("response request taken after end-of-data");
  a_single_done: assert property (
    r.act == MODE_SINGLE && r.state == ST_IFR && tx_done && !arb_lost
      && !sw_ctrl_wr |=> !r.single_req && r.state == ST_IDLE)
    else $error("single response not cleared after success");
  a_single_retry: assert property (
    lost_single |=> r.state == ST_RETRY && !r.sym_valid)
    else $error("single response did not wait to retry");
  a_retry_resend: assert property (
    r.state == ST_RETRY && rx_byte_done && !bus_error && !sw_eod_wr
      |=> r.state == ST_IFR ##[1:2] (r.sym_valid && r.sym_kind == SYM_BYTE))
    else $error("retry did not resend the byte without norm bit");
  a_last_bit_ones: assert property (
    lost_multi_last |=> r.state == ST_TRAILER ##1 ones_out)
    else $error("no trailing ones after last-bit loss");
  a_multi_arb_clear: assert property (
    arb_lost && r.act == MODE_CRC && r.state == ST_IFR && !sw_ctrl_wr
      |=> !r.crc_req && r.arb_flag && r.state != ST_IFR)
    else $error("crc response still active after loss");
  a_underrun_clear: assert property (
    r.state == ST_IFR && r.act == MODE_NOCRC && idle_tx && !r.shift_full
      && !r.buf_full && !r.eod_req && !sw_ctrl_wr && !arb_lost
      |=> !r.nocrc_req ##1 ones_out)
    else $error("underrun did not end the response");

endmodule : sfrt_tx_control

// ---- tb/sfrt_enc_model.sv ----
// ****************************************************************
// symbol encoder and bus: one symbol on the wire at a time
// ****************************************************************
module sfrt_enc_model #(
  parameter int LAT = 30
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sym_valid,
  input wire sfrt_pkg::sfrt_sym_type sym_kind,
  input wire logic [7:0] sym_data,
  input wire logic sym_norm,
  input wire logic abort,
  output logic sym_ready,
  output logic tx_done,
  output logic crc_first_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  import sfrt_pkg::*;
  int cnt;
  int n;
  sfrt_sym_type kind_q [0:31];
  logic [8:0] val_q [0:31];

  // ready only while the wire is free, so a new symbol never overlaps
  assign sym_ready = (cnt == 0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      n <= 0;
      tx_done <= 1'b0;
      crc_first_bit <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      crc_first_bit <= 1'b0;
      // a lost or broken symbol never reports completion
      if (abort) begin
        cnt <= 0;
      end else if (cnt == 1) begin
        tx_done <= 1'b1;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (sym_valid) begin
        kind_q[n] <= sym_kind;
        val_q[n] <= {sym_norm, sym_data};
        n <= n + 1;
        cnt <= LAT;
        crc_first_bit <= (sym_kind == SYM_CRC);
      end
    end
  end
endmodule : sfrt_enc_model

// ---- tb/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sfrt_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic rx_eod_ok = 1'b0, rx_eof = 1'b0, bus_error = 1'b0;
  logic arb_lost = 1'b0, arb_lost_last_bit = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_rready = 1'b0, rx_byte_done = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sym_valid, sym_norm, sym_ready, tx_done;
  logic crc_first_bit;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] sym_data;
  sfrt_sym_type sym_kind;
  int fails = 0, cmp_count = 0, cyc = 0, b;

  sfrt_tx_control dut (
    .clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sym_valid, .sym_kind, .sym_data,
    .sym_norm, .sym_ready, .tx_done, .crc_first_bit, .arb_lost,
    .arb_lost_last_bit, .bus_error, .rx_eod_ok, .rx_eof,
    .rx_byte_done, .peer_norm_seen(1'b0)
  );

  sfrt_enc_model #(.LAT(30)) enc (
    .clk, .arst_n, .sym_valid, .sym_kind, .sym_data, .sym_norm,
    .abort(arb_lost | bus_error), .sym_ready, .tx_done, .crc_first_bit
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // bus tasks and comparison
  // ****************************************************************
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // bready and rready stand high until the answer; one edge passes after
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axw

  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk($sformatf("rdata %h", a), s_axi_rdata & m, e);
    chk($sformatf("rresp %h", a), 32'(s_axi_rresp),
        (a > 8'h0c) ? 32'h2 : 32'h0);
    @(posedge clk);
  endtask : rc

  // 0 end-of-data seen, 1 end of frame, 2 bus error, 3 arbitration lost,
  // 4 winning byte done
  task automatic pulse(input int w);
    case (w)
      0: rx_eod_ok <= 1'b1;
      1: rx_eof <= 1'b1;
      2: bus_error <= 1'b1;
      4: rx_byte_done <= 1'b1;
      default: arb_lost <= 1'b1;
    endcase
    @(posedge clk);
    {rx_eod_ok, rx_eof, bus_error, arb_lost, rx_byte_done} <= 5'h0;
    @(posedge clk);
  endtask : pulse

  task automatic wn(input int k);
    while (enc.n < k) @(posedge clk);
  endtask : wn

  task automatic wid;
    while (enc.cnt != 0 || sym_valid) @(posedge clk);
  endtask : wid

  task automatic sc(input int i, input sfrt_sym_type k,
                    input logic [7:0] v);
    chk("sym_kind", 32'(enc.kind_q[i]), 32'(k));
    if (k == SYM_BYTE) chk("sym_data", 32'(enc.val_q[i][7:0]), 32'(v));
    if (k == SYM_NORM) chk("sym_norm", 32'(enc.val_q[i][8]), 32'(v[0]));
  endtask : sc

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rc(8'h00, 32'hffffffff, 32'h0);
    rc(8'h08, 32'hffffffff, 32'h0);
    rc(8'h10, 32'hffffffff, 32'h0);
    // normal message: end-of-data lands with a byte still held
    axw(8'h04, 32'ha5);
    wn(1);
    rc(8'h08, 32'hff, 32'h10);
    axw(8'h04, 32'h3c);
    rc(8'h08, 32'hff, 32'h10);
    axw(8'h04, 32'h77);
    rc(8'h08, 32'hff, 32'h00);
    axw(8'h00, 32'h10);
    wn(4);
    sc(0, SYM_BYTE, 8'ha5);
    sc(1, SYM_BYTE, 8'h3c);
    sc(2, SYM_BYTE, 8'h77);
    sc(3, SYM_CRC, 8'h00);
    rc(8'h00, 32'h10, 32'h00);
    wid;
    pulse(1);
    // all three response bits written together
    b = enc.n;
    axw(8'h00, 32'h07);
    axw(8'h04, 32'h5a);
    rc(8'h00, 32'hff, 32'h07);
    pulse(0);
    wn(b + 1);
    rc(8'h0c, 32'h30, 32'h10);
    wn(b + 2);
    sc(b, SYM_NORM, 8'h00);
    sc(b + 1, SYM_BYTE, 8'h5a);
    wid;
    rc(8'h00, 32'h04, 32'h00);
    axw(8'h00, 32'h00);
    wid;
    pulse(1);
    // no-crc response with inverted norm format, lost on last bit
    b = enc.n;
    axw(8'h00, 32'h09);
    axw(8'h04, 32'h81);
    pulse(0);
    wn(b + 2);
    sc(b, SYM_NORM, 8'h01);
    arb_lost_last_bit <= 1'b1;
    pulse(3);
    wn(b + 3);
    sc(b + 2, SYM_ONES, 8'h00);
    rc(8'h00, 32'hff, 32'h08);
    wid;
    arb_lost_last_bit <= 1'b0;
    rc(8'h08, 32'hff, 32'h14);
    axw(8'h00, 32'h00);
    pulse(1);
    // single byte plus crc response
    b = enc.n;
    axw(8'h00, 32'h02);
    axw(8'h04, 32'h42);
    pulse(0);
    wn(b + 2);
    rc(8'h08, 32'hff, 32'h10);
    axw(8'h00, 32'h12);
    rc(8'h08, 32'hff, 32'h00);
    wn(b + 4);
    sc(b, SYM_NORM, 8'h01);
    sc(b + 1, SYM_BYTE, 8'h42);
    sc(b + 2, SYM_CRC, 8'h00);
    sc(b + 3, SYM_EOD, 8'h00);
    rc(8'h08, 32'hff, 32'h00);
    wid;
    pulse(0);
    rc(8'h00, 32'hff, 32'h00);
    pulse(1);
    // request made after end-of-data already seen
    b = enc.n;
    pulse(0);
    axw(8'h00, 32'h04);
    rc(8'h00, 32'hff, 32'h00);
    chk("sym_count", 32'(enc.n), 32'(b));
    pulse(1);
    // single response lost on its last bit, retried after the winner
    b = enc.n;
    axw(8'h00, 32'h04);
    axw(8'h04, 32'h66);
    pulse(0);
    wn(b + 2);
    arb_lost_last_bit <= 1'b1;
    pulse(3);
    arb_lost_last_bit <= 1'b0;
    pulse(4);
    wn(b + 3);
    sc(b + 2, SYM_BYTE, 8'h66);
    wid;
    rc(8'h00, 32'hff, 32'h00);
    rc(8'h08, 32'hff, 32'h14);
    pulse(1);
    // with-crc response lost mid byte: no retry
    b = enc.n;
    axw(8'h00, 32'h02);
    axw(8'h04, 32'h55);
    pulse(0);
    wn(b + 2);
    pulse(3);
    rc(8'h00, 32'hff, 32'h00);
    rc(8'h08, 32'hff, 32'h14);
    wid;
    chk("sym_count", 32'(enc.n), 32'(b + 2));
    pulse(1);
    // no-crc response left without a next byte
    b = enc.n;
    axw(8'h00, 32'h01);
    axw(8'h04, 32'h55);
    pulse(0);
    wn(b + 3);
    sc(b + 2, SYM_ONES, 8'h00);
    rc(8'h00, 32'hff, 32'h00);
    wid;
    pulse(1);
    for (int i = 0; i < 3; i++) begin
      axw(8'h00, 32'h1 << i);
      pulse(2);
      rc(8'h00, 32'hff, 32'h00);
    end
    complete_run();
  end
endmodule : tb
